/* dv/host_clock_output_test.sv */
/*
 Self-checking bench for the host clock output generator.
 Assumes a crystal tick on every cycle while enabled and a low-frequency
 half-period of LF_HALF cycles.
*/
`timescale 1ns/10ps
module host_clock_output_test;
   import host_clock_pkg::*;
   localparam int LF_HALF = 8;
   logic sys_clk = 1'b0, sys_rst = 1'b1;
   logic [6:0] reg_addr = 7'h00;
   logic [7:0] reg_wdata = 8'h00, reg_rdata, d, r;
   logic reg_we = 1'b0, reg_re = 1'b0, sw_reset_req = 1'b0, sleep_cmd = 1'b0;
   logic xtal_tick = 1'b0, lf_tick = 1'b0, irq_raise = 1'b0;
   logic irq_pending, xtal_enable, sw_reset_active, clock_output_pin;
   int fall_count, last_period, n_errors = 0, checks_done = 0, cycles = 0;
   int lf_cnt = 0, f0, seed;
   always #5 sys_clk = ~sys_clk;
   host_clock_output #(.SW_RST_CYCLES(8)) u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .sw_reset_req(sw_reset_req), .sleep_cmd(sleep_cmd),
      .irq_pending(irq_pending), .xtal_tick(xtal_tick), .lf_tick(lf_tick),
      .xtal_enable(xtal_enable), .sw_reset_active(sw_reset_active),
      .clock_output_pin(clock_output_pin));
   host_mcu_model u_host (.sys_clk(sys_clk), .sys_rst(sys_rst),
      .clock_output_pin(clock_output_pin), .irq_raise(irq_raise),
      .irq_pending(irq_pending), .fall_count(fall_count), .last_period(last_period));
   // Oscillator ticks; the crystal only ticks while it is enabled
   always @(posedge sys_clk) begin
      xtal_tick <= xtal_enable;
      lf_cnt <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
      lf_tick <= (lf_cnt == LF_HALF - 1);
   end
   // Hang guard sized well above the tail tests
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         n_errors++;
         $display("unexpected run length: expected %0d seen %0d", 59999, cycles);
         results();
      end
   end
   function automatic int exp_period(input logic [2:0] c);
      int p[8] = '{2, 4, 6, 15, 20, 30, 60, 2 * LF_HALF};
      return p[c];
   endfunction : exp_period
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : results
   task automatic cmp8(input string what, input logic [7:0] e, input logic [7:0] g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   endtask : cmp8
   task automatic cmp1(input string what, input logic e, input logic g);
      checks_done++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s: expected %b seen %b", what, e, g);
      end
   endtask : cmp1
   task automatic cmp32(input string what, input int e, input int g);
      checks_done++;
      if (g != e) begin
         n_errors++;
         $display("unexpected %s: expected %0d seen %0d", what, e, g);
      end
   endtask : cmp32
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic wr(input logic [6:0] a, input logic [7:0] v);
      reg_addr = a;
      reg_wdata = v;
      reg_we = 1'b1;
      cyc(1);
      reg_we = 1'b0;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] v);
      reg_addr = a;
      reg_re = 1'b1;
      cyc(1);
      reg_re = 1'b0;
      cyc(1);
      v = reg_rdata;
   endtask : rd
   // Bounded wait for n more falls of the host clock
   task automatic wait_falls(input int n);
      int f, k;
      f = fall_count + n;
      k = 0;
      while (fall_count < f && k < 5000) begin
         cyc(1);
         k++;
      end
      if (k >= 5000) cmp32("clock_output_pin falls", f, fall_count);
   endtask : wait_falls
   task automatic chk_period(input string what, input int e);
      wait_falls(3);
      cmp32(what, e, last_period);
   endtask : chk_period
   task automatic wait_xtal_off();
      int k;
      k = 0;
      while (xtal_enable !== 1'b0 && k < 9000) begin
         cyc(1);
         k++;
      end
   endtask : wait_xtal_off
   initial begin
      seed = 32'h53A5EB72;
      cyc(8);
      sys_rst = 1'b0;
      rd(CLKCTL_ADDR, d);
      cmp8("control after reset", CLKCTL_RESET, d);
      rd(7'h05, d);
      cmp8("unmapped read", 8'h00, d);
      chk_period("default period", 15);
      $display("test reset done");
      // Every divider code, with random junk in the unused top bits
      for (int i = 0; i < 8; i++) begin
         r = $random(seed);
         wr(CLKCTL_ADDR, {r[7:6], 3'b000, i[2:0]});
         rd(CLKCTL_ADDR, d);
         cmp8("control readback", {5'h00, i[2:0]}, d);
         chk_period("divider period", exp_period(i[2:0]));
      end
      wr(7'h0B, 8'hFF);
      rd(CLKCTL_ADDR, d);
      cmp8("control after stray write", 8'h07, d);
      $display("test divider done");
      // Low-frequency clock replaces the 30 MHz choice in SLEEP
      wr(CLKCTL_ADDR, 8'h08);
      sleep_cmd = 1'b1;
      chk_period("sleep period", 2 * LF_HALF);
      cmp1("xtal_enable in sleep", 1'b0, xtal_enable);
      sleep_cmd = 1'b0;
      chk_period("wake period", 2);
      $display("test sleep clock done");
      // Clock tail then stop, sleep raised just after a fall
      for (int t = 0; t < 4; t++) begin
         wr(CLKCTL_ADDR, {2'b00, t[1:0], 4'h3});
         wait_falls(3);
         wait_falls(1);
         sleep_cmd = 1'b1;
         f0 = fall_count;
         wait_xtal_off();
         cmp32("tail falls", (t == 0) ? 0 : 64 << t, fall_count - f0);
         f0 = fall_count;
         cyc(100);
         cmp32("falls while stopped", 0, fall_count - f0);
         cmp1("stopped pin", 1'b0, clock_output_pin);
         cmp1("xtal_enable stopped", 1'b0, xtal_enable);
         sleep_cmd = 1'b0;
         chk_period("period after tail", 15);
      end
      $display("test tail done");
      // Pending interrupt holds clock and crystal until the host reads it
      wr(CLKCTL_ADDR, 8'h03);
      irq_raise = 1'b1;
      cyc(1);
      irq_raise = 1'b0;
      sleep_cmd = 1'b1;
      for (int j = 0; j < 10; j++) begin
         wait_falls(1);
         cmp1("xtal_enable with irq", 1'b1, xtal_enable);
      end
      wait_xtal_off();
      cmp1("irq after status read", 1'b0, irq_pending);
      cmp1("xtal_enable after read", 1'b0, xtal_enable);
      sleep_cmd = 1'b0;
      $display("test interrupt done");
      // Software reset restores the default and blocks writes
      wr(CLKCTL_ADDR, 8'h35);
      sw_reset_req = 1'b1;
      cyc(1);
      sw_reset_req = 1'b0;
      cyc(1);
      cmp1("sw_reset_active", 1'b1, sw_reset_active);
      wr(CLKCTL_ADDR, 8'h21);
      rd(CLKCTL_ADDR, d);
      cmp8("control in sw reset", CLKCTL_RESET, d);
      cyc(10);
      cmp1("sw_reset_active end", 1'b0, sw_reset_active);
      rd(CLKCTL_ADDR, d);
      cmp8("control after sw reset", CLKCTL_RESET, d);
      $display("test software reset done");
      results();
   end
endmodule : host_clock_output_test

/* dv/host_mcu_model.sv */
/*
 Behavioural host controller that runs from the clock output pin: counts
 falling edges, times the last period and reads the interrupt status.
 Assumes the pin is a registered level on sys_clk.
*/
`timescale 1ns/10ps
module host_mcu_model #(
   parameter int READ_DELAY = 20 // Host clock falls before status read
)(
   input wire logic sys_clk, // System clock
   input wire logic sys_rst, // Async reset, active high
   input wire logic clock_output_pin, // Host clock in
   input wire logic irq_raise, // Interrupt event pulse
   output logic irq_pending, // Interrupt not yet read
   output int fall_count, // Falling edges seen
   output int last_period // Cycles between last two falls
);
   logic pin_reg;
   int gap_reg;
   int wait_reg;
   // Edge detector and period timer in system clock cycles
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_reg <= 1'b0;
         gap_reg <= 0;
         fall_count <= 0;
         last_period <= 0;
      end else begin
         pin_reg <= clock_output_pin;
         if (pin_reg && !clock_output_pin) begin
            fall_count <= fall_count + 1;
            last_period <= gap_reg;
            gap_reg <= 1;
         end else begin
            gap_reg <= gap_reg + 1;
         end
      end
   end
   // Status read runs on the host clock, so a stopped clock never clears it
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_pending <= 1'b0;
         wait_reg <= 0;
      end else if (irq_raise) begin
         irq_pending <= 1'b1;
         wait_reg <= READ_DELAY;
      end else if (irq_pending && pin_reg && !clock_output_pin) begin
         if (wait_reg == 1) irq_pending <= 1'b0;
         wait_reg <= wait_reg - 1;
      end
   end
endmodule : host_mcu_model

/* rtl/crystal_divider.sv */
/*
 * Divides the crystal half-period tick into the selected host clock.
 * Assumes tick pulses once per crystal half-period while the crystal runs.
 */
`timescale 1ns/10ps
module crystal_divider
   import host_clock_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic sys_rst, // Async reset, active high
   input wire logic tick, // Crystal half-period enable
   input wire logic [2:0] sel, // Divider select code
   output logic div_out // Divided clock level
);

   logic [6:0] period_reg;
   logic [6:0] cnt_reg;
   logic [6:0] cnt_next;

   // A new select takes effect only at the period boundary, so no runt appears
   assign cnt_next = (cnt_reg == period_reg - 7'h01) ? 7'h00 : cnt_reg + 7'h01;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_reg <= 7'h00;
         period_reg <= PER_1M;
         div_out <= 1'b0;
      end else if (tick) begin
         cnt_reg <= cnt_next;
         if (cnt_next == 7'h00) begin
            period_reg <= div_period(sel);
         end
         // High for the first half, low for the rest (4 MHz is 7 high, 8 low)
         div_out <= (cnt_next < (((cnt_next == 7'h00) ? div_period(sel) : period_reg) >> 1));
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   AST_PERIOD_LOAD: assert property (tick && cnt_next == 7'h00 |=> period_reg == div_period($past(sel)))
      else $error("divider period not taken from select at boundary");
   AST_PERIOD_SPAN: assert property (tick && cnt_reg == 7'h00 |-> period_reg >= PER_30M)
      else $error("divider period below two half ticks");

endmodule : crystal_divider

/* rtl/glitchless_switch.sv */
/*
 * Glitch-free selector for the clock output pin: parks the pin low while
 * the old source is low and joins the new source on its falling edge.
 * Assumes both source levels come from flip-flops on sys_clk.
 */
`timescale 1ns/10ps
module glitchless_switch
   import host_clock_pkg::*;
(
   input wire logic sys_clk, // System clock
   input wire logic sys_rst, // Async reset, active high
   input wire logic div_in, // Crystal-derived clock level
   input wire logic lf_in, // Low-frequency clock level
   input src_t req, // Requested source
   output src_t cur_sel, // Source now on the pin
   output logic clk_out // Clock output pin level
);

   sw_state_t state_reg;
   src_t target_reg;
   logic div_d;
   logic lf_d;
   logic cur_val;
   logic tgt_fall;

   assign cur_val = (cur_sel == SRC_DIV) ? div_in : (cur_sel == SRC_LF) ? lf_in : 1'b0;
   assign tgt_fall = (target_reg == SRC_DIV) ? (div_d && !div_in) :
                     (target_reg == SRC_LF) ? (lf_d && !lf_in) : 1'b1;

   // Previous source levels for fall detection
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         div_d <= 1'b0;
         lf_d <= 1'b0;
      end else begin
         div_d <= div_in;
         lf_d <= lf_in;
      end
   end

   // Leaving a source only while it is low and joining the next on its fall
   // keeps every high and low phase at least as long as the shorter source
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= SW_RUN;
         cur_sel <= SRC_STOP;
         target_reg <= SRC_STOP;
         clk_out <= 1'b0;
      end else begin
         case (state_reg)
            SW_RUN: begin
               if (req != cur_sel && !cur_val) begin
                  state_reg <= SW_PARK;
                  target_reg <= req;
                  clk_out <= 1'b0;
               end else begin
                  clk_out <= cur_val;
               end
            end
            default: begin
               clk_out <= 1'b0;
               if (tgt_fall) begin
                  cur_sel <= target_reg;
                  state_reg <= SW_RUN;
               end else begin
                  target_reg <= req;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   AST_PARK_LOW: assert property (state_reg == SW_PARK |=> !clk_out)
      else $error("clock pin high while switching sources");
   AST_LEAVE_LOW: assert property (state_reg == SW_RUN && $changed(cur_sel) |-> $past(!clk_out))
      else $error("source changed while pin high");

endmodule : glitchless_switch

/* rtl/host_clock_output.sv */
/*
 * Host clock output generator: control register, power-state tracking,
 * clock tail, crystal enable and the clock output pin.
 * Assumes register accesses arrive on a simple synchronous port decoded
 * from the serial interface, crystal and low-frequency half-period ticks
 * synchronous to sys_clk, and an interrupt-pending level from the status
 * logic that drops when the host reads the interrupt status.
 */
`timescale 1ns/10ps

module host_clock_output
   import host_clock_pkg::*;
#(
   parameter int SW_RST_CYCLES = SW_RESET_CYCLES // Software reset stretch
)(
   input wire logic sys_clk, // System clock, 100 MHz
   input wire logic sys_rst, // Async reset, active high
   input wire logic [6:0] reg_addr, // Register address
   input wire logic [7:0] reg_wdata, // Register write data
   input wire logic reg_we, // Register write strobe
   input wire logic reg_re, // Register read strobe
   output logic [7:0] reg_rdata, // Register read data
   input wire logic sw_reset_req, // Software reset request pulse
   input wire logic sleep_cmd, // SLEEP commanded
   input wire logic irq_pending, // Interrupt not yet read
   input wire logic xtal_tick, // Crystal half-period enable
   input wire logic lf_tick, // Low-frequency half-period enable
   output logic xtal_enable, // Crystal oscillator enable
   output logic sw_reset_active, // Software reset in progress
   output logic clock_output_pin // Host clock out
);

   localparam logic [12:0] SW_RST_LAST = 13'(SW_RST_CYCLES - 1);

   logic [7:0] ctl_reg;
   logic [12:0] swr_cnt_reg;
   pwr_state_t state_reg;
   logic [9:0] tail_cnt_reg;
   logic lf_clk_reg;
   logic pin_d;
   logic pin_fall;
   logic eff_sleep;
   logic lfc_en;
   logic [1:0] tail_code;
   logic [2:0] div_sel;
   logic xtal_next;
   logic div_clk;
   src_t src_req;
   src_t cur_sel;

   assign lfc_en = ctl_reg[LFC_BIT];
   assign tail_code = ctl_reg[TAIL_MSB:TAIL_LSB];
   assign div_sel = ctl_reg[DIV_MSB:DIV_LSB];

   // A pending interrupt holds off any sleep until its status is read
   assign eff_sleep = sleep_cmd && !irq_pending;

   // Software reset stretch; the request restarts the count if repeated
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         swr_cnt_reg <= 13'h0000;
         sw_reset_active <= 1'b0;
      end else if (sw_reset_req) begin
         swr_cnt_reg <= 13'h0000;
         sw_reset_active <= 1'b1;
      end else if (sw_reset_active) begin
         swr_cnt_reg <= swr_cnt_reg + 13'h0001;
         if (swr_cnt_reg == SW_RST_LAST) begin
            sw_reset_active <= 1'b0;
         end
      end
   end

   // Control register; bits 7:6 are unused and read as zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctl_reg <= CLKCTL_RESET;
      end else if (sw_reset_active) begin
         ctl_reg <= CLKCTL_RESET;
      end else if (reg_we && reg_addr == CLKCTL_ADDR) begin
         ctl_reg <= {2'b00, reg_wdata[TAIL_MSB:DIV_LSB]};
      end
   end

   // Read port; unmapped addresses answer zero
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_re) begin
         if (reg_addr == CLKCTL_ADDR) begin
            reg_rdata <= ctl_reg;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // Low-frequency clock level from its half-period tick
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         lf_clk_reg <= 1'b0;
      end else if (lf_tick) begin
         lf_clk_reg <= !lf_clk_reg;
      end
   end

   // Pin fall detect paces the tail count in whole host clock cycles
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_d <= 1'b0;
      end else begin
         pin_d <= clock_output_pin;
      end
   end
   assign pin_fall = pin_d && !clock_output_pin;

   // Power state and clock tail. Counting falls of the pin rather than
   // divider periods keeps the tail exact across a source switch, and a
   // sleep command withdrawn mid-tail returns straight to the awake state.
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_AWAKE;
         tail_cnt_reg <= TAIL_NONE;
      end else begin
         case (state_reg)
            ST_AWAKE: begin
               if (eff_sleep) begin
                  if (lfc_en || tail_code == 2'h0) begin
                     state_reg <= ST_SLEEP;
                  end else begin
                     tail_cnt_reg <= tail_len(tail_code);
                     state_reg <= ST_TAIL;
                  end
               end
            end
            ST_TAIL: begin
               if (!eff_sleep) begin
                  tail_cnt_reg <= TAIL_NONE;
                  state_reg <= ST_AWAKE;
               end else if (lfc_en) begin
                  // Enable set mid-tail hands the pin to the slow clock at once
                  tail_cnt_reg <= TAIL_NONE;
                  state_reg <= ST_SLEEP;
               end else if (pin_fall) begin
                  tail_cnt_reg <= tail_cnt_reg - 10'h001;
                  if (tail_cnt_reg == 10'h001) begin
                     state_reg <= ST_SLEEP;
                  end
               end
            end
            default: begin
               if (!eff_sleep) begin
                  state_reg <= ST_AWAKE;
               end
            end
         endcase
      end
   end

   // Source request; the tail keeps the divider-selected clock alive.
   // Code 111 outside SLEEP still routes the low-frequency clock.
   always_comb begin
      if (state_reg == ST_SLEEP && lfc_en) begin
         src_req = SRC_LF;
      end else if (state_reg == ST_SLEEP) begin
         src_req = SRC_STOP;
      end else if (div_sel == DIV_SEL_LF) begin
         src_req = SRC_LF;
      end else begin
         src_req = SRC_DIV;
      end
   end

   // Crystal stays on until the switch has let go of the divided clock,
   // so the last divided cycle is never cut short
   assign xtal_next = !eff_sleep || state_reg != ST_SLEEP || cur_sel == SRC_DIV;

   // Registered so the oscillator enable never glitches on a mux change
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         xtal_enable <= 1'b1;
      end else begin
         xtal_enable <= xtal_next;
      end
   end

   // Crystal divider; it freezes mid-period while the crystal is off
   crystal_divider u_div (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .tick(xtal_tick && xtal_enable),
      .sel(div_sel),
      .div_out(div_clk)
   );

   // Glitch-free output switch between divided, slow and stopped clocks
   glitchless_switch u_sw (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .div_in(div_clk),
      .lf_in(lf_clk_reg),
      .req(src_req),
      .cur_sel(cur_sel),
      .clk_out(clock_output_pin)
   );

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   sequence s_sleep_entry_tail;
      state_reg == ST_AWAKE && eff_sleep && !lfc_en;
   endsequence

   sequence s_tail_last_fall;
      state_reg == ST_TAIL && eff_sleep && !lfc_en && pin_fall && tail_cnt_reg == 10'h001;
   endsequence

   sequence s_tail_mid_fall;
      state_reg == ST_TAIL && eff_sleep && !lfc_en && pin_fall && tail_cnt_reg != 10'h001;
   endsequence

   AST_SWRST_DEFAULT: assert property (sw_reset_active |=> ctl_reg == CLKCTL_RESET)
      else $error("control register not at default during software reset");
   AST_DEFAULT_HOST_CLK: assert property ($fell(sw_reset_active)
      |-> src_req == SRC_DIV || state_reg == ST_SLEEP)
      else $error("default configuration does not select the divided clock");
   AST_REG_WRITE: assert property (reg_we && reg_addr == CLKCTL_ADDR && !sw_reset_active
      |=> ctl_reg == {2'b00, $past(reg_wdata[5:0])})
      else $error("control register write not stored");
   AST_REG_READ: assert property (reg_re && reg_addr == CLKCTL_ADDR |=> reg_rdata == $past(ctl_reg))
      else $error("control register read mismatch");
   AST_LF_IN_SLEEP: assert property (state_reg == ST_SLEEP && lfc_en |-> src_req == SRC_LF)
      else $error("sleep with low-frequency enable not on low-frequency clock");
   AST_AWAKE_DIV: assert property (state_reg == ST_AWAKE && div_sel != DIV_SEL_LF
      |-> src_req == SRC_DIV)
      else $error("awake state not on divided clock");
   AST_LF_CODE: assert property (state_reg != ST_SLEEP && div_sel == DIV_SEL_LF
      |-> src_req == SRC_LF)
      else $error("code 111 not on low-frequency clock");
   AST_XTAL_OFF: assert property (state_reg == ST_SLEEP && eff_sleep && cur_sel != SRC_DIV
      |=> !xtal_enable)
      else $error("crystal left running in sleep");
   AST_STOP_IN_SLEEP: assert property (state_reg == ST_SLEEP && !lfc_en |-> src_req == SRC_STOP)
      else $error("clock not stopped in sleep without low-frequency enable");
   AST_TAIL_LOAD: assert property (s_sleep_entry_tail and (tail_code != 2'h0)
      |=> state_reg == ST_TAIL && tail_cnt_reg == tail_len($past(tail_code)))
      else $error("clock tail length not loaded");
   AST_TAIL_END: assert property (s_tail_last_fall
      |=> state_reg == ST_SLEEP && (lfc_en || src_req == SRC_STOP))
      else $error("clock tail did not end after its last cycle");
   AST_IRQ_HOLD: assert property (irq_pending |=> xtal_enable && state_reg != ST_TAIL
      || $past(state_reg) == ST_TAIL)
      else $error("pending interrupt let the clock stop");
   AST_IRQ_WAKE: assert property (state_reg == ST_SLEEP && irq_pending |=> state_reg == ST_AWAKE)
      else $error("pending interrupt did not restore the commanded clock");

   // Register port, software reset, tail, crystal and stopped-pin checks
   AST_SWRST_START: assert property (sw_reset_req |=> sw_reset_active)
      else $error("software reset request did not start the stretch");
   AST_UNMAPPED_READ: assert property (reg_re && reg_addr != CLKCTL_ADDR
      |=> reg_rdata == 8'h00)
      else $error("unmapped read did not answer zero");
   AST_RDATA_HOLD: assert property (!reg_re |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   AST_CTL_UNUSED: assert property (ctl_reg[7:6] == 2'b00)
      else $error("unused control bits not zero");
   AST_SLEEP_DIRECT: assert property (state_reg == ST_AWAKE && eff_sleep
      && (lfc_en || tail_code == 2'h0) |=> state_reg == ST_SLEEP)
      else $error("sleep without tail not entered at once");
   AST_TAIL_STEP: assert property (s_tail_mid_fall
      |=> state_reg == ST_TAIL && tail_cnt_reg == $past(tail_cnt_reg) - 10'h001)
      else $error("clock tail count did not step on a pin fall");
   AST_TAIL_ABORT: assert property (state_reg == ST_TAIL && !eff_sleep
      |=> state_reg == ST_AWAKE)
      else $error("withdrawn sleep did not end the clock tail");
   AST_XTAL_WAKE: assert property (!eff_sleep |=> xtal_enable)
      else $error("crystal not running while awake");
   AST_PIN_STOPPED: assert property (cur_sel == SRC_STOP |-> !clock_output_pin)
      else $error("clock pin high with the stopped source selected");

endmodule : host_clock_output

/* rtl/host_clock_pkg.sv */
/*
 * Shared constants for the host clock output generator: register map,
 * field layout, reset value, divider periods, clock tail lengths and
 * the software reset stretch time.
 * Assumes a 100 MHz system clock and a crystal half-period enable pulse.
 */
package host_clock_pkg;

   // Register map
   localparam logic [6:0] CLKCTL_ADDR = 7'h0A;
   localparam logic [7:0] CLKCTL_RESET = 8'h0B;

   // Field positions in the control register
   localparam int TAIL_MSB = 5;
   localparam int TAIL_LSB = 4;
   localparam int LFC_BIT = 3;
   localparam int DIV_MSB = 2;
   localparam int DIV_LSB = 0;

   // Divider select code that routes the low-frequency clock
   localparam logic [2:0] DIV_SEL_LF = 3'h7;

   // Tail lengths in host clock cycles
   localparam logic [9:0] TAIL_NONE = 10'h000;
   localparam logic [9:0] TAIL_128 = 10'h080;
   localparam logic [9:0] TAIL_256 = 10'h100;
   localparam logic [9:0] TAIL_512 = 10'h200;

   // Output periods counted in crystal half-periods (60 MHz ticks)
   localparam logic [6:0] PER_30M = 7'h02;
   localparam logic [6:0] PER_15M = 7'h04;
   localparam logic [6:0] PER_10M = 7'h06;
   localparam logic [6:0] PER_4M = 7'h0F;
   localparam logic [6:0] PER_3M = 7'h14;
   localparam logic [6:0] PER_2M = 7'h1E;
   localparam logic [6:0] PER_1M = 7'h3C;

   // Software reset pulse time, least value, and the system clock rate
   localparam int SW_RESET_PULSE_TIME_US = 50;
   localparam int SYS_CLK_MHZ = 100;
   localparam int SW_RESET_CYCLES = SW_RESET_PULSE_TIME_US * SYS_CLK_MHZ;

   // Sources of the clock output pin
   typedef enum logic [1:0] {
      SRC_STOP = 2'b00,
      SRC_DIV = 2'b01,
      SRC_LF = 2'b11
   } src_t;

   // Power states seen by the output logic (Gray along awake-tail-sleep)
   typedef enum logic [1:0] {
      ST_AWAKE = 2'b00,
      ST_TAIL = 2'b01,
      ST_SLEEP = 2'b11
   } pwr_state_t;

   // Switch states (Gray along run-park-run)
   typedef enum logic [1:0] {
      SW_RUN = 2'b00,
      SW_PARK = 2'b01
   } sw_state_t;

   function automatic logic [6:0] div_period(input logic [2:0] sel);
      logic [6:0] p;
      p = PER_1M;
      case (sel)
         3'h0: p = PER_30M;
         3'h1: p = PER_15M;
         3'h2: p = PER_10M;
         3'h3: p = PER_4M;
         3'h4: p = PER_3M;
         3'h5: p = PER_2M;
         default: p = PER_1M;
      endcase
      return p;
   endfunction : div_period

   function automatic logic [9:0] tail_len(input logic [1:0] code);
      logic [9:0] n;
      n = TAIL_NONE;
      case (code)
         2'h1: n = TAIL_128;
         2'h2: n = TAIL_256;
         2'h3: n = TAIL_512;
         default: n = TAIL_NONE;
      endcase
      return n;
   endfunction : tail_len

endpackage : host_clock_pkg
